// ==== vic_defines.svh ====
// Offsets, field positions, reset values and timing counts of the vectored
// interrupt controller with its timer, capture and wake-up sources.
// Assumes a 100 MHz MCLK and an 8-bit register port with 5 address bits.
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// Register offsets on the plain register port.
`define VIC_OFF_STAT_LO   5'h00
`define VIC_OFF_STAT_HI   5'h01
`define VIC_OFF_MASK_LO   5'h02
`define VIC_OFF_MASK_HI   5'h03
`define VIC_OFF_CTRL      5'h04
`define VIC_OFF_TMR_LO    5'h05
`define VIC_OFF_TMR_HI    5'h06
`define VIC_OFF_CAP_CFG   5'h07
`define VIC_OFF_CAPA_RISE 5'h08
`define VIC_OFF_CAPA_FALL 5'h09
`define VIC_OFF_CAPB_RISE 5'h0a
`define VIC_OFF_CAPB_FALL 5'h0b
`define VIC_OFF_GMASK_LO  5'h0c
`define VIC_OFF_GMASK_HI  5'h0d
`define VIC_OFF_GPOL_LO   5'h0e
`define VIC_OFF_GPOL_HI   5'h0f
`define VIC_OFF_CSP       5'h10

// Control register fields.
`define VIC_CTRL_GIE  0
`define VIC_CTRL_PS2  1
`define VIC_CTRL_WAKE 2

// Capture configuration fields.
`define VIC_CAPCFG_PRE_LSB 0
`define VIC_CAPCFG_PRE_MSB 2
`define VIC_CAPCFG_A_RISE  3
`define VIC_CAPCFG_A_FALL  4
`define VIC_CAPCFG_B_RISE  5
`define VIC_CAPCFG_B_FALL  6
`define VIC_CAP_PRE_MAX    3'h4

// Source bit and vector numbers, lowest number served first.
`define VIC_NSRC       10
`define VIC_SRC_BUSRST 0
`define VIC_SRC_T128   1
`define VIC_SRC_T1024  2
`define VIC_SRC_EP0    3
`define VIC_SRC_CAPA   6
`define VIC_SRC_CAPB   7
`define VIC_SRC_GPIO   8
`define VIC_SRC_WAKE   9

// Reset values.
`define VIC_RST_BYTE 8'h00
`define VIC_RST_SRC  10'h000

// Timing.
`define VIC_CLK_PERIOD_NS  10
`define VIC_TICK_PERIOD_NS 1000
`define VIC_TICK_CYCLES    (`VIC_TICK_PERIOD_NS / `VIC_CLK_PERIOD_NS)
`define VIC_TAP128_MASK    12'h07f
`define VIC_TAP1024_MASK   12'h3ff
`define VIC_WAKE_PERIOD_US 1000
`define VIC_WAKE_CYCLES    (`VIC_WAKE_PERIOD_US * 1000 / `VIC_CLK_PERIOD_NS)

`endif

// ==== vic_pkg.sv ====
// Types shared by the interrupt controller and its source modules.
// Assumes vic_defines.svh for every numeric constant.
`default_nettype none

package vic_pkg;
   typedef logic [7:0]  vic_byte_t;
   typedef logic [4:0]  vic_addr_t;
   typedef logic [9:0]  vic_src_t;
   typedef logic [3:0]  vic_vec_t;
   typedef logic [13:0] vic_pc_t;
   typedef enum {VIC_IDLE, VIC_PUSH_LO, VIC_PUSH_HI} vic_push_e;
endpackage

`default_nettype wire

// ==== vic_capture_chan.sv ====
// One capture channel: latches a counter slice on each pin edge.
// Assumes the pin input is already synchronised to MCLK.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.svh"

module vic_capture_chan
   import vic_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   // Pin and counter slice.
   input  wire logic      pin,
   input  wire vic_byte_t slice,
   // Captured values and one-cycle edge pulses.
   output vic_byte_t      rise_q,
   output vic_byte_t      fall_q,
   output logic           rise_evt,
   output logic           fall_evt
);
   logic prev_q;

   // Edge detection against the previous synchronised sample.
   assign rise_evt = ce & pin & ~prev_q;
   assign fall_evt = ce & ~pin & prev_q;

   // Rising and falling edges each own a capture register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_q <= 1'b0;
         rise_q <= `VIC_RST_BYTE;
         fall_q <= `VIC_RST_BYTE;
      end
      else if (ce)
      begin
         prev_q <= pin;
         if (rise_evt)
            rise_q <= slice;
         if (fall_evt)
            fall_q <= slice;
      end
   end
endmodule

`default_nettype wire

// ==== vic_gpio_edge.sv ====
// Per-pin GPIO edge detector merged onto one request line.
// Assumes pins are already synchronised to MCLK.
`timescale 1ns/100ps
`default_nettype none

module vic_gpio_edge
#(
   parameter int W = 16
)
(
   // Clock, reset and enable.
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Pins and per-pin settings; polarity high selects the rising edge.
   input  wire logic [W-1:0] pins,
   input  wire logic [W-1:0] mask,
   input  wire logic [W-1:0] pol,
   // One-cycle pulse when any enabled pin sees its edge.
   output logic              hit
);
   logic [W-1:0] prev_q;
   logic [W-1:0] pin_hit;

   // Each pin chooses its own edge and its own mask bit.
   for (genvar i = 0; i < W; i++)
   begin : g_pin
      assign pin_hit[i] = mask[i] & (pol[i] ? (pins[i] & ~prev_q[i])
                                            : (~pins[i] & prev_q[i]));
   end

   // All pins share one request, there is no per-pin vector.
   assign hit = ce & (|pin_hit);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= '0;
      else if (ce)
         prev_q <= pins;
   end
endmodule

`default_nettype wire

// ==== vic_irq_ctrl.sv ====
// Vectored interrupt controller with its free-running timer, capture
// channels, GPIO edge sources, PS/2 activity and suspend wake-up timer.
// Assumes a core on MCLK that pulses IRQ_ACK and a stack RAM write port.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.svh"

module vic_irq_ctrl
   import vic_pkg::*;
#(
   parameter int GPIO_W      = 16,
   parameter int WAKE_CYCLES = `VIC_WAKE_CYCLES
)
(
   // Clock, reset and clock enable.
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   // Register port.
   input  wire vic_pkg::vic_addr_t ADDR,
   input  wire vic_pkg::vic_byte_t WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output vic_pkg::vic_byte_t     RDATA,
   // Asynchronous pins.
   input  wire logic [GPIO_W-1:0] GPIO_IN,
   input  wire logic              PS2_CLK_IN,
   input  wire logic              PS2_DATA_IN,
   // Same-clock USB and power events.
   input  wire logic              USB_BUS_RESET,
   input  wire logic [2:0]        EP_DONE,
   input  wire logic              SUSPEND,
   // Core interrupt handshake.
   output logic                   IRQ,
   output vic_pkg::vic_vec_t      VECTOR,
   input  wire logic              IRQ_ACK,
   input  wire vic_pkg::vic_pc_t  RET_PC,
   input  wire logic              RET_CARRY,
   input  wire logic              RET_ZERO,
   // Stack write port.
   output logic                   STACK_WE,
   output vic_pkg::vic_byte_t     STACK_ADDR,
   output vic_pkg::vic_byte_t     STACK_WDATA
);
   import vic_pkg::*;

   localparam logic [6:0]  TICK_LAST = 7'(`VIC_TICK_CYCLES - 1);
   localparam logic [23:0] WAKE_LAST = 24'(WAKE_CYCLES - 1);
   localparam int          SYNC_W    = GPIO_W + 2;

   // True when the port addresses the given register.
   function automatic logic addr_is(input vic_addr_t a, input vic_addr_t off);
      return a == off;
   endfunction

   // Lowest pending source number, which is also the vector.
   function automatic vic_vec_t lowest_index(input vic_src_t v);
      vic_vec_t idx;
      idx = '0;
      for (int i = `VIC_NSRC - 1; i >= 0; i--)
         if (v[i])
            idx = 4'(i);
      return idx;
   endfunction

   // Selects an eight-bit counter slice; settings above the top clamp.
   function automatic vic_byte_t cap_slice(input logic [11:0] c,
                                           input logic [2:0]  pre);
      logic [2:0]  p;
      logic [11:0] s;
      p = (pre > `VIC_CAP_PRE_MAX) ? `VIC_CAP_PRE_MAX : pre;
      s = c >> p;
      return s[7:0];
   endfunction

   // Synchroniser and register state.
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic [1:0]        ps2_prev_q;
   logic [6:0]        pre_q;
   logic [11:0]       cnt_q;
   logic [3:0]        tmr_hi_q;
   logic [23:0]       wake_q;
   vic_src_t          stat_q;
   vic_src_t          stat_d;
   vic_src_t          mask_q;
   vic_byte_t         ctrl_q;
   vic_byte_t         capcfg_q;
   logic [15:0]       gmask_q;
   logic [15:0]       gpol_q;
   vic_byte_t         csp_q;
   vic_push_e         push_q;
   vic_byte_t         push_hi_q;
   logic              gie_d;

   // Internal nets.
   logic [GPIO_W-1:0] gpio_s;
   logic              tick;
   logic              tap128;
   logic              tap1024;
   logic              ps2_act;
   logic              wake_evt;
   logic              gpio_hit;
   vic_byte_t         slice;
   vic_byte_t         capa_rise;
   vic_byte_t         capa_fall;
   vic_byte_t         capb_rise;
   vic_byte_t         capb_fall;
   logic              capa_r_evt;
   logic              capa_f_evt;
   logic              capb_r_evt;
   logic              capb_f_evt;
   vic_src_t          src_set;
   vic_src_t          src_clr;
   vic_src_t          pend_d;
   vic_byte_t         rd_mux;
   logic              ack_take;

   // Two flip-flops on every pin before anything looks at it.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else if (CE)
      begin
         meta_q <= {PS2_DATA_IN, PS2_CLK_IN, GPIO_IN};
         sync_q <= meta_q;
      end
   end

   assign gpio_s = sync_q[GPIO_W-1:0];

   // The 1 MHz tick divides MCLK; the counter simply wraps at 12 bits.
   assign tick    = CE & (pre_q == TICK_LAST);
   assign tap128  = tick & ((cnt_q & `VIC_TAP128_MASK) == `VIC_TAP128_MASK);
   assign tap1024 = tick & ((cnt_q & `VIC_TAP1024_MASK) == `VIC_TAP1024_MASK);

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pre_q <= '0;
         cnt_q <= '0;
      end
      else if (CE)
      begin
         pre_q <= tick ? 7'h00 : pre_q + 7'h01;
         if (tick)
            cnt_q <= cnt_q + 12'h001;
      end
   end

   // Capture channels on port 0 bits 0 and 1 share one counter slice.
   assign slice = cap_slice(cnt_q,
                     capcfg_q[`VIC_CAPCFG_PRE_MSB:`VIC_CAPCFG_PRE_LSB]);

   vic_capture_chan u_cap_a
   (
      .clk      (MCLK),
      .rst_n    (RST_N),
      .ce       (CE),
      .pin      (gpio_s[0]),
      .slice    (slice),
      .rise_q   (capa_rise),
      .fall_q   (capa_fall),
      .rise_evt (capa_r_evt),
      .fall_evt (capa_f_evt)
   );

   vic_capture_chan u_cap_b
   (
      .clk      (MCLK),
      .rst_n    (RST_N),
      .ce       (CE),
      .pin      (gpio_s[1]),
      .slice    (slice),
      .rise_q   (capb_rise),
      .fall_q   (capb_fall),
      .rise_evt (capb_r_evt),
      .fall_evt (capb_f_evt)
   );

   vic_gpio_edge #(.W(GPIO_W)) u_gpio
   (
      .clk   (MCLK),
      .rst_n (RST_N),
      .ce    (CE),
      .pins  (gpio_s),
      .mask  (gmask_q[GPIO_W-1:0]),
      .pol   (gpol_q[GPIO_W-1:0]),
      .hit   (gpio_hit)
   );

   // PS/2 activity is any change on clock or data while PS/2 mode is on.
   assign ps2_act = CE & ctrl_q[`VIC_CTRL_PS2] &
                    (|(sync_q[SYNC_W-1:GPIO_W] ^ ps2_prev_q));

   // Wake-up timer only counts while suspended and enabled.
   assign wake_evt = CE & ctrl_q[`VIC_CTRL_WAKE] & SUSPEND &
                     (wake_q == WAKE_LAST);

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ps2_prev_q <= '0;
         wake_q     <= '0;
      end
      else if (CE)
      begin
         ps2_prev_q <= sync_q[SYNC_W-1:GPIO_W];
         if (!(ctrl_q[`VIC_CTRL_WAKE] & SUSPEND) || wake_evt)
            wake_q <= '0;
         else
            wake_q <= wake_q + 24'h000001;
      end
   end

   // Source events; bus reset and PS/2 activity share vector 0.
   assign src_set[`VIC_SRC_BUSRST] = CE & (USB_BUS_RESET | ps2_act);
   assign src_set[`VIC_SRC_T128]   = tap128;
   assign src_set[`VIC_SRC_T1024]  = tap1024;
   assign src_set[`VIC_SRC_EP0+2:`VIC_SRC_EP0] = {3{CE}} & EP_DONE;
   assign src_set[`VIC_SRC_CAPA] =
      (capa_r_evt & capcfg_q[`VIC_CAPCFG_A_RISE]) |
      (capa_f_evt & capcfg_q[`VIC_CAPCFG_A_FALL]);
   assign src_set[`VIC_SRC_CAPB] =
      (capb_r_evt & capcfg_q[`VIC_CAPCFG_B_RISE]) |
      (capb_f_evt & capcfg_q[`VIC_CAPCFG_B_FALL]);
   assign src_set[`VIC_SRC_GPIO] = gpio_hit;
   assign src_set[`VIC_SRC_WAKE] = wake_evt;

   // An acknowledge is only honoured while a request is being shown.
   assign ack_take = CE & IRQ_ACK & IRQ & (push_q == VIC_IDLE);

   // Reads of a status byte and an acknowledge clear; a new event wins.
   assign src_clr = ({10{CE & RD & addr_is(ADDR, `VIC_OFF_STAT_LO)}}
                     & 10'h0ff)
                  | ({10{CE & RD & addr_is(ADDR, `VIC_OFF_STAT_HI)}}
                     & 10'h300)
                  | (ack_take ? (10'h001 << VECTOR) : 10'h000);
   assign stat_d  = (stat_q & ~src_clr) | src_set;
   assign pend_d  = stat_d & mask_q;

   // Global enable: set by firmware, dropped by the acknowledge.
   assign gie_d = ack_take ? 1'b0 :
                  (CE & WR & addr_is(ADDR, `VIC_OFF_CTRL)) ?
                     WDATA[`VIC_CTRL_GIE] : ctrl_q[`VIC_CTRL_GIE];

   // Status, request line and vector are all registered.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         stat_q <= `VIC_RST_SRC;
         IRQ    <= 1'b0;
         VECTOR <= '0;
      end
      else if (CE)
      begin
         stat_q <= stat_d;
         IRQ    <= gie_d & (|pend_d);
         VECTOR <= lowest_index(pend_d);
      end
   end

   // Firmware-written configuration.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mask_q   <= `VIC_RST_SRC;
         ctrl_q   <= `VIC_RST_BYTE;
         capcfg_q <= `VIC_RST_BYTE;
         gmask_q  <= '0;
         gpol_q   <= '0;
      end
      else if (CE)
      begin
         ctrl_q[`VIC_CTRL_GIE] <= gie_d;
         if (WR)
         begin
            if (addr_is(ADDR, `VIC_OFF_MASK_LO))
               mask_q[7:0] <= WDATA;
            if (addr_is(ADDR, `VIC_OFF_MASK_HI))
               mask_q[9:8] <= WDATA[1:0];
            if (addr_is(ADDR, `VIC_OFF_CTRL))
               ctrl_q[7:1] <= WDATA[7:1];
            if (addr_is(ADDR, `VIC_OFF_CAP_CFG))
               capcfg_q <= WDATA;
            if (addr_is(ADDR, `VIC_OFF_GMASK_LO))
               gmask_q[7:0] <= WDATA;
            if (addr_is(ADDR, `VIC_OFF_GMASK_HI))
               gmask_q[15:8] <= WDATA;
            if (addr_is(ADDR, `VIC_OFF_GPOL_LO))
               gpol_q[7:0] <= WDATA;
            if (addr_is(ADDR, `VIC_OFF_GPOL_HI))
               gpol_q[15:8] <= WDATA;
         end
      end
   end

   // Read data mux; unmapped addresses read as zero.
   assign rd_mux =
      addr_is(ADDR, `VIC_OFF_STAT_LO)   ? stat_q[7:0] :
      addr_is(ADDR, `VIC_OFF_STAT_HI)   ? {6'h00, stat_q[9:8]} :
      addr_is(ADDR, `VIC_OFF_MASK_LO)   ? mask_q[7:0] :
      addr_is(ADDR, `VIC_OFF_MASK_HI)   ? {6'h00, mask_q[9:8]} :
      addr_is(ADDR, `VIC_OFF_CTRL)      ? ctrl_q :
      addr_is(ADDR, `VIC_OFF_TMR_LO)    ? cnt_q[7:0] :
      addr_is(ADDR, `VIC_OFF_TMR_HI)    ? {4'h0, tmr_hi_q} :
      addr_is(ADDR, `VIC_OFF_CAP_CFG)   ? capcfg_q :
      addr_is(ADDR, `VIC_OFF_CAPA_RISE) ? capa_rise :
      addr_is(ADDR, `VIC_OFF_CAPA_FALL) ? capa_fall :
      addr_is(ADDR, `VIC_OFF_CAPB_RISE) ? capb_rise :
      addr_is(ADDR, `VIC_OFF_CAPB_FALL) ? capb_fall :
      addr_is(ADDR, `VIC_OFF_GMASK_LO)  ? gmask_q[7:0] :
      addr_is(ADDR, `VIC_OFF_GMASK_HI)  ? gmask_q[15:8] :
      addr_is(ADDR, `VIC_OFF_GPOL_LO)   ? gpol_q[7:0] :
      addr_is(ADDR, `VIC_OFF_GPOL_HI)   ? gpol_q[15:8] :
      addr_is(ADDR, `VIC_OFF_CSP)       ? csp_q : 8'h00;

   // Reading the low timer byte freezes the high nibble so a 12-bit
   // reading cannot tear across a carry between the two reads.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         RDATA    <= `VIC_RST_BYTE;
         tmr_hi_q <= '0;
      end
      else if (CE)
      begin
         RDATA <= RD ? rd_mux : 8'h00;
         if (RD && addr_is(ADDR, `VIC_OFF_TMR_LO))
            tmr_hi_q <= cnt_q[11:8];
      end
   end

   // Acknowledge pushes PC low byte, then flags with PC high bits.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         push_q      <= VIC_IDLE;
         push_hi_q   <= `VIC_RST_BYTE;
         csp_q       <= `VIC_RST_BYTE;
         STACK_WE    <= 1'b0;
         STACK_ADDR  <= `VIC_RST_BYTE;
         STACK_WDATA <= `VIC_RST_BYTE;
      end
      else if (CE)
      begin
         STACK_WE <= 1'b0;
         unique case (push_q)
            VIC_IDLE:
            begin
               if (ack_take)
               begin
                  push_q      <= VIC_PUSH_LO;
                  STACK_WE    <= 1'b1;
                  STACK_ADDR  <= csp_q;
                  STACK_WDATA <= RET_PC[7:0];
                  push_hi_q   <= {RET_CARRY, RET_ZERO, RET_PC[13:8]};
                  csp_q       <= csp_q + 8'h01;
               end
               else if (WR && addr_is(ADDR, `VIC_OFF_CSP))
                  csp_q <= WDATA;
            end
            VIC_PUSH_LO:
            begin
               push_q      <= VIC_PUSH_HI;
               STACK_WE    <= 1'b1;
               STACK_ADDR  <= csp_q;
               STACK_WDATA <= push_hi_q;
               csp_q       <= csp_q + 8'h01;
            end
            VIC_PUSH_HI:
               push_q <= VIC_IDLE;
         endcase
      end
   end
endmodule

`default_nettype wire

// ==== vic_core_model.sv ====
// Behavioural core: acknowledges standing requests and holds stack RAM.
// Assumes the controller's registered IRQ, VECTOR and stack write port.
`timescale 1ns/100ps
`default_nettype none

module vic_core_model
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Handshake; lag sets how many cycles the core stays busy.
   input  wire logic [3:0]         lag,
   input  wire logic               irq,
   input  wire vic_pkg::vic_vec_t  vector,
   output logic                    ack,
   output vic_pkg::vic_vec_t       last_vec,
   // Stack write port.
   input  wire logic               we,
   input  wire vic_pkg::vic_byte_t waddr,
   input  wire vic_pkg::vic_byte_t wdata
);
   import vic_pkg::*;
   vic_byte_t  mem [256];
   logic [3:0] wait_q;
   logic       go;

   // One pulse per request; a busy core lets the request stand a while.
   assign go = irq && !ack && wait_q >= lag;

   // Stack writes land in RAM so the bench can see what was pushed.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack <= 1'b0;
         wait_q <= 4'h0;
         last_vec <= 4'h0;
      end
      else
      begin
         ack <= go;
         wait_q <= (irq && !ack) ? wait_q + 4'h1 : 4'h0;
         if (go)
            last_vec <= vector;
         if (we)
            mem[waddr] <= wdata;
      end
   end
endmodule

`default_nettype wire

// ==== vic_irq_checker.sv ====
// Checker for the register port, the events and the stack push.
// Assumes CE stays high and sees only the controller's top ports.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.svh"

module vic_irq_checker
(
   // Clock and reset.
   input  wire logic               MCLK,
   input  wire logic               RST_N,
   // Register port.
   input  wire vic_pkg::vic_addr_t ADDR,
   input  wire logic               RD,
   input  wire vic_pkg::vic_byte_t RDATA,
   // Events.
   input  wire logic               USB_BUS_RESET,
   input  wire logic [2:0]         EP_DONE,
   // Core handshake and stack port.
   input  wire logic               IRQ,
   input  wire vic_pkg::vic_vec_t  VECTOR,
   input  wire logic               IRQ_ACK,
   input  wire vic_pkg::vic_pc_t   RET_PC,
   input  wire logic               RET_CARRY,
   input  wire logic               RET_ZERO,
   input  wire logic               STACK_WE,
   input  wire vic_pkg::vic_byte_t STACK_ADDR,
   input  wire vic_pkg::vic_byte_t STACK_WDATA
);
   import vic_pkg::*;
   logic        take;
   logic        take_q;
   logic [15:0] ret_q;

   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // An acknowledge only counts while a request stands.
   assign take = IRQ && IRQ_ACK;

   // Keeps what the core offered, since it may change during the push.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         take_q <= 1'b0;
         ret_q <= 16'h0000;
      end
      else
      begin
         take_q <= take;
         if (take)
            ret_q <= {RET_CARRY, RET_ZERO, RET_PC};
      end
   end

   a_push_low_byte: assert property (
      take |=> STACK_WE && STACK_WDATA == ret_q[7:0])
      else $error("first pushed byte wrong");
   a_push_flag_byte: assert property (
      take |=> ##1 STACK_WE && STACK_WDATA == ret_q[15:8]
         && STACK_ADDR == $past(STACK_ADDR) + 8'h01)
      else $error("second pushed byte wrong");
   a_ack_masks_irq: assert property (
      take |=> !IRQ [*2] ##1 !STACK_WE)
      else $error("request or push went on after acknowledge");
   a_push_needs_ack: assert property (
      $rose(STACK_WE) |-> take_q)
      else $error("stack write without acknowledge");
   a_rdata_one_cycle: assert property (
      !RD |=> RDATA == 8'h00)
      else $error("read data outside its cycle");
   a_ep_sets_status: assert property (
      $fell(EP_DONE[1]) ##1 (RD && ADDR == `VIC_OFF_STAT_LO)
      |=> RDATA[`VIC_SRC_EP0 + 1])
      else $error("endpoint event not in status");
   a_busrst_status: assert property (
      $fell(USB_BUS_RESET) ##1 (RD && ADDR == `VIC_OFF_STAT_LO)
      |=> RDATA[`VIC_SRC_BUSRST])
      else $error("bus reset not in status");
   a_unmapped_zero: assert property (
      RD && ADDR > `VIC_OFF_CSP |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_vector_range: assert property (
      IRQ |-> VECTOR < 4'ha)
      else $error("vector out of range");
endmodule

bind vic_irq_ctrl vic_irq_checker u_chk (.MCLK(MCLK), .RST_N(RST_N),
   .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .USB_BUS_RESET(USB_BUS_RESET),
   .EP_DONE(EP_DONE), .IRQ(IRQ), .VECTOR(VECTOR), .IRQ_ACK(IRQ_ACK),
   .RET_PC(RET_PC), .RET_CARRY(RET_CARRY), .RET_ZERO(RET_ZERO),
   .STACK_WE(STACK_WE), .STACK_ADDR(STACK_ADDR),
   .STACK_WDATA(STACK_WDATA));

`default_nettype wire

// ==== vic_irq_ctrl_tb_top.sv ====
// Self-checking bench for the interrupt controller and its sources.
// Assumes vic_core_model as the core and a shortened wake-up period.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defines.svh"

module vic_irq_ctrl_tb_top;
   import vic_pkg::*;
   logic        MCLK = 1'b0;
   logic        RST_N = 1'b0;
   vic_addr_t   ADDR = 5'h00;
   vic_byte_t   WDATA = 8'h00;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic [15:0] GPIO_IN = 16'h0000;
   logic        PS2_DATA_IN = 1'b0, PS2_CLK_IN = 1'b0;
   logic        USB_BUS_RESET = 1'b0;
   logic [2:0]  EP_DONE = 3'h0;
   logic        SUSPEND = 1'b0;
   logic [3:0]  lag = 4'h0;
   vic_byte_t   RDATA, STACK_ADDR, STACK_WDATA, v, hi;
   vic_vec_t    VECTOR, last_vec;
   logic        IRQ, IRQ_ACK, STACK_WE;
   logic [11:0] t0, c;
   int          errors = 0;
   int          cmp_count = 0;

   always #5 MCLK = ~MCLK;

   vic_irq_ctrl #(.WAKE_CYCLES(20)) DUT (.MCLK(MCLK),
      .RST_N(RST_N), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .GPIO_IN(GPIO_IN), .PS2_CLK_IN(PS2_CLK_IN),
      .PS2_DATA_IN(PS2_DATA_IN), .USB_BUS_RESET(USB_BUS_RESET),
      .EP_DONE(EP_DONE), .SUSPEND(SUSPEND), .IRQ(IRQ), .VECTOR(VECTOR),
      .IRQ_ACK(IRQ_ACK), .RET_PC(14'h2a5c), .RET_CARRY(1'b1),
      .RET_ZERO(1'b0), .STACK_WE(STACK_WE), .STACK_ADDR(STACK_ADDR),
      .STACK_WDATA(STACK_WDATA));
   vic_core_model core (.clk(MCLK), .rst_n(RST_N), .lag(lag), .irq(IRQ),
      .vector(VECTOR), .ack(IRQ_ACK), .last_vec(last_vec),
      .we(STACK_WE), .waddr(STACK_ADDR), .wdata(STACK_WDATA));

   task chk(input string n, input logic [11:0] s, input logic [11:0] e);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task wr(input vic_addr_t a, input vic_byte_t d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task rd(input vic_addr_t a, output vic_byte_t d);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask

   task rchk(input string n, input vic_addr_t a, input vic_byte_t m,
             input vic_byte_t e);
      vic_byte_t d;
      rd(a, d);
      chk(n, {4'h0, d & m}, {4'h0, e});
   endtask

   task ev(input logic br, input logic [2:0] ep);
      @(posedge MCLK);
      USB_BUS_RESET <= br;
      EP_DONE <= ep;
      @(posedge MCLK);
      USB_BUS_RESET <= 1'b0;
      EP_DONE <= 3'h0;
   endtask
   // Waits on the core's acknowledge, then until both pushed bytes sit
   // in the core's memory, so the memory is never read as it is written.
   task await_ack(input int lim, input vic_vec_t e);
      for (int i = 0; i < lim && IRQ_ACK !== 1'b1; i++)
         @(negedge MCLK);
      chk("ack_vector", {8'h0, last_vec}, {8'h0, e});
      repeat (3) @(negedge MCLK);
   endtask

   task rtmr(output logic [11:0] t);
      rd(`VIC_OFF_TMR_LO, v);
      rd(`VIC_OFF_TMR_HI, hi);
      t = {hi[3:0], v};
   endtask

   task tally_and_finish;
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Cuts a hang short well after the longest wait, the 128 us timer tap.
   initial
   begin
      repeat (20000) @(posedge MCLK);
      errors++;
      tally_and_finish;
   end

   initial
   begin
      repeat (3) @(posedge MCLK);
      RST_N <= 1'b1;
      rchk("ctrl_rst", `VIC_OFF_CTRL, 8'hff, 8'h00);
      rchk("mask_rst", `VIC_OFF_MASK_LO, 8'hff, 8'h00);
      rchk("csp_rst", `VIC_OFF_CSP, 8'hff, 8'h00);
      wr(5'h1f, 8'hff);
      rchk("unmapped", 5'h1f, 8'hff, 8'h00);
      wr(`VIC_OFF_CTRL, 8'hf8);
      rchk("ctrl_rw", `VIC_OFF_CTRL, 8'hff, 8'hf8);
      // Any 300-cycle span holds exactly three microsecond ticks.
      rtmr(t0);
      repeat (296) @(posedge MCLK);
      rtmr(c);
      chk("tmr_delta", c - t0, 12'h003);
      // A masked source is recorded but raises no request.
      wr(`VIC_OFF_MASK_LO, 8'h08);
      wr(`VIC_OFF_CTRL, 8'h01);
      ev(1'b0, 3'h2);
      @(negedge MCLK) chk("irq_masked", {11'h0, IRQ}, 12'h000);
      rchk("ep1_stat", `VIC_OFF_STAT_LO, 8'h10, 8'h10);
      rchk("ep1_clear", `VIC_OFF_STAT_LO, 8'h10, 8'h00);
      // Two endpoints at once: the lower vector goes first.
      wr(`VIC_OFF_CTRL, 8'h00);
      wr(`VIC_OFF_MASK_LO, 8'h29);
      ev(1'b0, 3'h5);
      wr(`VIC_OFF_CTRL, 8'h01);
      await_ack(50, 4'h3);
      chk("push_lo", {4'h0, core.mem[0]}, 12'h05c);
      chk("push_hi", {4'h0, core.mem[1]}, 12'h0aa);
      lag <= 4'h5;
      wr(`VIC_OFF_CTRL, 8'h01);
      await_ack(50, 4'h5);
      rchk("csp_step", `VIC_OFF_CSP, 8'hff, 8'h04);
      lag <= 4'h0;
      ev(1'b1, 3'h0);
      rchk("busrst", `VIC_OFF_STAT_LO, 8'h01, 8'h01);
      // GPIO: pin 5 on rising, pin 12 on falling, pin 3 not enabled.
      wr(`VIC_OFF_GMASK_LO, 8'h20);
      wr(`VIC_OFF_GMASK_HI, 8'h10);
      wr(`VIC_OFF_GPOL_LO, 8'h20);
      GPIO_IN <= 16'h1008;
      repeat (4) @(posedge MCLK);
      rchk("gpio_quiet", `VIC_OFF_STAT_HI, 8'h01, 8'h00);
      GPIO_IN <= 16'h0008;
      repeat (4) @(posedge MCLK);
      rchk("gpio_fall", `VIC_OFF_STAT_HI, 8'h01, 8'h01);
      GPIO_IN <= 16'h0028;
      repeat (4) @(posedge MCLK);
      rchk("gpio_rise", `VIC_OFF_STAT_HI, 8'h01, 8'h01);
      // Capture A at prescale 4; only the rising edge may interrupt.
      wr(`VIC_OFF_CAP_CFG, 8'h0c);
      rtmr(c);
      GPIO_IN <= 16'h0029;
      repeat (6) @(posedge MCLK);
      rd(`VIC_OFF_CAPA_RISE, v);
      chk("cap_rise", {11'h0, v - c[11:4] < 8'h02}, 12'h001);
      rchk("cap_int", `VIC_OFF_STAT_LO, 8'h40, 8'h40);
      GPIO_IN <= 16'h0028;
      repeat (6) @(posedge MCLK);
      rd(`VIC_OFF_CAPA_FALL, v);
      chk("cap_fall", {11'h0, v - c[11:4] < 8'h02}, 12'h001);
      rchk("cap_gated", `VIC_OFF_STAT_LO, 8'h40, 8'h00);
      // The 128 us tap raises vector 1 within one tap period.
      wr(`VIC_OFF_MASK_LO, 8'h02);
      rd(`VIC_OFF_STAT_LO, v);
      wr(`VIC_OFF_CTRL, 8'h01);
      await_ack(13000, 4'h1);
      // PS/2 activity and the wake-up timer while suspended.
      wr(`VIC_OFF_CTRL, 8'h06);
      PS2_DATA_IN <= 1'b1;
      SUSPEND <= 1'b1;
      repeat (40) @(posedge MCLK);
      rchk("ps2_act", `VIC_OFF_STAT_LO, 8'h01, 8'h01);
      rchk("wake", `VIC_OFF_STAT_HI, 8'h02, 8'h02);
      tally_and_finish;
   end
endmodule

`default_nettype wire
